// file: comparator_control_regs.sv
// APB register block and digital logic around an analog comparator
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "comparator_control_regs.svh"
module comparator_control_regs
	import comparator_control_pkg::*;
#(
	parameter int SYNC_STAGES = 3
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        standby_sleep,
	input  wire logic        analog_compare,
	output logic             comparator_on,
	output logic             low_power_select,
	output logic      [1:0]  hysteresis_select,
	output logic      [1:0]  positive_input_select,
	output logic      [1:0]  negative_input_select,
	output logic      [7:0]  divider_reference_code,
	output logic             pad_out,
	output logic             pad_out_en,
	output logic             event_level,
	output logic             irq
);
	// Timing as software sees it:
	// - every APB access is answered in its first access cycle, no waits
	// - configuration fields reach the analog side one clock after a write; the divider code drives it straight from its register
	// - the state bit lags the comparator by SYNC_STAGES clocks
	// - the flag sets one clock after the synchronised edge, the request
	//   one clock after that
	// Limitation: pulses shorter than a clock period may be missed, since
	// the raw decision is sampled, not latched; a glitch filter would add
	// latency that software polling the state bit would also see.
	// Standby freezes the synchroniser and the setting of the flag together, so a change
	// that happened while the clock stood still is seen on wake-up as a
	// level change and still sets the flag once.

	initial begin
		if (SYNC_STAGES < 2)
			$error("SYNC_STAGES must be at least 2");
	end

	logic [7:0]             comparator_control;
	logic [7:0]             input_select;
	logic [7:0]             interrupt_enable;
	logic                   compare_irq_bit;
	logic [SYNC_STAGES-1:0] sync;
	logic                   state_prev;
	logic                   running;
	logic                   clock_live;
	logic                   out_now;
	logic                   rise;
	logic                   fall;
	logic                   edge_hit;
	logic                   acc;
	logic                   wr;
	logic                   clear_req;
	edge_select_type        edge_select;

	// Access phase; this slave never waits, so every access is one cycle
	assign acc = psel && penable;
	assign wr  = acc && pwrite && pstrb[0];
	assign edge_select = edge_select_type'(comparator_control[`EDGE_BITS]);

	// Standby halts the comparator unless told to keep running
	assign running = comparator_control[`BIT_ENABLE] &&
		(!standby_sleep || comparator_control[`BIT_STANDBY_RUN]);
	// The peripheral clock stands still in standby: synchroniser and flag setting freeze
	assign clock_live = !standby_sleep;

	// Analog decision is one when positive exceeds negative; invert
	assign out_now = running &&
		(analog_compare ^ input_select[`BIT_INVERT]);

	// Control register: enable, modes and standby behaviour
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comparator_control <= `RESET_CONTROL;
		else if (wr && paddr == `OFFSET_CONTROL)
			comparator_control <= pwdata[7:0];
	end

	// Input selection; unused bits are masked so they read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			input_select <= `RESET_INPUT_SELECT;
		else if (wr && paddr == `OFFSET_INPUT_SELECT)
			input_select <= pwdata[7:0] & `MASK_INPUT_SELECT;
	end

	// Divider code; resets to full scale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			divider_reference_code <= `RESET_REFERENCE;
		else if (wr && paddr == `OFFSET_REFERENCE)
			divider_reference_code <= pwdata[7:0];
	end

	// Interrupt enable; only the request enable bit is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			interrupt_enable <= `RESET_INT_ENABLE;
		else if (wr && paddr == `OFFSET_INT_ENABLE)
			interrupt_enable <= pwdata[7:0] & `MASK_INT_ENABLE;
	end

	// Analog-facing controls are registered copies of the fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_on         <= 1'b0;
			low_power_select      <= 1'b0;
			hysteresis_select     <= 2'h0;
			positive_input_select <= 2'h0;
			negative_input_select <= 2'h0;
		end else begin
			comparator_on         <= running;
			low_power_select      <= comparator_control[`BIT_LOW_POWER];
			hysteresis_select     <= comparator_control[`HYST_BITS];
			positive_input_select <= input_select[`POS_BITS];
			negative_input_select <= input_select[`NEG_BITS];
		end
	end

	// Pad and event follow the output; registered, so one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out     <= 1'b0;
			pad_out_en  <= 1'b0;
			event_level <= 1'b0;
		end else begin
			pad_out     <= out_now;
			pad_out_en  <= comparator_control[`BIT_PAD_ENABLE];
			event_level <= out_now;
		end
	end

	// Synchroniser; only the last stage is looked at, hence SYNC_STAGES cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync       <= '0;
			state_prev <= 1'b0;
		end else if (clock_live) begin
			sync       <= {sync[SYNC_STAGES-2:0], out_now};
			state_prev <= sync[SYNC_STAGES-1];
		end
	end

	// Edge detection on the synchronised level
	assign rise = sync[SYNC_STAGES-1] && !state_prev;
	assign fall = !sync[SYNC_STAGES-1] && state_prev;
	always_comb begin
		case (edge_select)
			either_edge:  edge_hit = rise || fall;
			falling_edge: edge_hit = fall;
			rising_edge:  edge_hit = rise;
			default:      edge_hit = 1'b0; // Reserved code raises nothing
		endcase
	end

	// Only a one in bit 0 clears; zero and the state bit are ignored
	assign clear_req = wr && (paddr == `OFFSET_STATUS) &&
		pwdata[`BIT_FLAG];

	// Flag: a set in the clearing cycle wins so no edge is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			compare_irq_bit <= 1'b0;
		else if (clock_live && edge_hit)
			compare_irq_bit <= 1'b1;
		else if (clear_req)
			compare_irq_bit <= 1'b0;
	end

	// Request follows flag and enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= compare_irq_bit && interrupt_enable[`BIT_IRQ_ENABLE];
	end

	// Read data; unmapped addresses read zero and answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == `OFFSET_CONTROL)
					prdata <= {24'h000000, comparator_control};
				else if (paddr == `OFFSET_INPUT_SELECT)
					prdata <= {24'h000000, input_select};
				else if (paddr == `OFFSET_REFERENCE)
					prdata <= {24'h000000, divider_reference_code};
				else if (paddr == `OFFSET_INT_ENABLE)
					prdata <= {24'h000000, interrupt_enable};
				else if (paddr == `OFFSET_STATUS)
					prdata <= {27'h0000000, sync[SYNC_STAGES-1], 3'h0,
						compare_irq_bit};
				else
					pslverr <= 1'b1;
			end
		end
	end

	// Checks on the flag: set on edges, set beats clear, clear works
	a_flag_on_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		clock_live && edge_hit |=> compare_irq_bit)
		else $error("flag not set after selected edge");
	a_set_beats_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		clock_live && edge_hit && clear_req |=> compare_irq_bit)
		else $error("clear beat a simultaneous set");
	a_clear_works: assert property (
		@(posedge pclk) disable iff (!presetn)
		clear_req && !(clock_live && edge_hit) |=> !compare_irq_bit)
		else $error("flag not cleared");
	a_reserved_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		edge_select == edge_reserved |-> !edge_hit)
		else $error("reserved edge code raised flag");

	// Checks on the request and its enable
	a_irq_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 irq == $past(compare_irq_bit && interrupt_enable[0]))
		else $error("request mismatch");
	a_irq_gated: assert property (
		@(posedge pclk) disable iff (!presetn)
		!interrupt_enable[`BIT_IRQ_ENABLE] |=> !irq)
		else $error("request raised while disabled");

	// Synchroniser lag once the three stages have all been clocked; flag held in standby
	a_state_lag: assert property (
		@(posedge pclk) disable iff (!presetn)
		clock_live [*3] ##1 1'b1 |->
		sync[SYNC_STAGES-1] == $past(out_now, 3))
		else $error("state bit lag wrong");
	a_standby_freeze: assert property (
		@(posedge pclk) disable iff (!presetn)
		!clock_live && !clear_req |=> $stable(compare_irq_bit))
		else $error("flag moved in standby");

	// Checks on what the analog side, pad and event network see
	a_halt_standby: assert property (
		@(posedge pclk) disable iff (!presetn)
		standby_sleep && !comparator_control[`BIT_STANDBY_RUN] |=>
		!comparator_on)
		else $error("comparator running in standby");
	a_enable_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 comparator_on == $past(running))
		else $error("comparator enable mismatch");
	a_pad_enable: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 pad_out_en == $past(comparator_control[`BIT_PAD_ENABLE]))
		else $error("pad enable mismatch");
	a_pad_value: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 pad_out == $past(out_now))
		else $error("pad value mismatch");
	a_event_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 event_level == $past(out_now))
		else $error("event level mismatch");
	a_low_power_copy: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 low_power_select == $past(comparator_control[`BIT_LOW_POWER]))
		else $error("low power select mismatch");
	a_hyst_copy: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 hysteresis_select == $past(comparator_control[`HYST_BITS]))
		else $error("hysteresis select mismatch");
	a_pos_copy: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 positive_input_select == $past(input_select[`POS_BITS]))
		else $error("positive select mismatch");
	a_neg_copy: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 negative_input_select == $past(input_select[`NEG_BITS]))
		else $error("negative select mismatch");

	// Main scenarios worth seeing
	c_rise_flag: cover property (@(posedge pclk) disable iff (!presetn)
		rise && edge_select == rising_edge ##1 compare_irq_bit);
	c_either_flag: cover property (@(posedge pclk) disable iff (!presetn)
		fall && edge_select == either_edge ##1 compare_irq_bit);
	c_fall_flag: cover property (@(posedge pclk) disable iff (!presetn)
		fall && edge_select == falling_edge ##1 compare_irq_bit);
	c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn)
		irq ##1 clear_req ##2 !irq);
	c_standby_run: cover property (@(posedge pclk) disable iff (!presetn)
		standby_sleep && comparator_on);
endmodule : comparator_control_regs
`default_nettype wire

// file: comparator_control_regs.svh
// Register map, field positions and reset values of the comparator control
`ifndef COMPARATOR_CONTROL_REGS_SVH
`define COMPARATOR_CONTROL_REGS_SVH
`define OFFSET_CONTROL      12'h000
`define OFFSET_INPUT_SELECT 12'h008
`define OFFSET_REFERENCE    12'h010
`define OFFSET_INT_ENABLE   12'h018
`define OFFSET_STATUS       12'h01c
`define RESET_CONTROL       8'h00
`define RESET_INPUT_SELECT  8'h00
`define RESET_REFERENCE     8'hff
`define RESET_INT_ENABLE    8'h00
`define BIT_STANDBY_RUN     7
`define BIT_PAD_ENABLE      6
`define BIT_LOW_POWER       3
`define BIT_ENABLE          0
`define BIT_INVERT          7
`define BIT_STATE           4
`define BIT_FLAG            0
`define EDGE_BOTH           2'h0
`define EDGE_FALLING        2'h2
`define EDGE_RISING         2'h3
`define EDGE_BITS           5:4
`define HYST_BITS           2:1
`define POS_BITS            4:3
`define NEG_BITS            1:0
`define BIT_IRQ_ENABLE      0
`define MASK_INPUT_SELECT   8'h9b
`define MASK_INT_ENABLE     8'h01
`endif

// file: comparator_control_pkg.sv
// Types shared by the comparator control logic
package comparator_control_pkg;
	typedef enum logic [1:0] {
		either_edge  = 2'h0,
		edge_reserved = 2'h1,
		falling_edge = 2'h2,
		rising_edge  = 2'h3
	} edge_select_type;
endpackage : comparator_control_pkg

// file: comparator_control_regs_test.sv
// Self-checking testbench for the comparator control register block
`timescale 1ns/1ns
`default_nettype none
`include "comparator_control_regs.svh"
module comparator_control_regs_test;
	logic        pclk, presetn, psel, penable, pwrite, standby_sleep;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, analog_compare, comparator_on, err;
	logic        low_power_select, pad_out, pad_out_en, event_level, irq;
	logic [1:0]  hys, pos_sel, neg_sel;
	logic [7:0]  div_code;
	int          n_mismatch, tests_run;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_type;
	// Every row writes then reads back; unused bits must read zero
	row_type     rows [4] = '{'{`OFFSET_CONTROL, 32'h7f, 32'h7f},
		'{`OFFSET_INPUT_SELECT, 32'hff, 32'h9b},
		'{`OFFSET_REFERENCE, 32'h5a, 32'h5a},
		'{`OFFSET_INT_ENABLE, 32'hff, 32'h01}};
	logic [11:0] raddr [5] = '{`OFFSET_CONTROL, `OFFSET_INPUT_SELECT,
		`OFFSET_REFERENCE, `OFFSET_INT_ENABLE, `OFFSET_STATUS};
	logic [31:0] rexp [5] = '{32'h00, 32'h00, 32'hff, 32'h00, 32'h00};
	logic [1:0]  modes [3] = '{`EDGE_BOTH, `EDGE_FALLING, `EDGE_RISING};

	comparator_control_regs dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standby_sleep(standby_sleep),
		.analog_compare(analog_compare), .comparator_on(comparator_on),
		.low_power_select(low_power_select), .hysteresis_select(hys),
		.positive_input_select(pos_sel), .negative_input_select(neg_sel),
		.divider_reference_code(div_code), .pad_out(pad_out),
		.pad_out_en(pad_out_en), .event_level(event_level), .irq(irq));

	// Free-running 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// One APB transfer; waits on pready with a bound, never a fixed count
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Move the analog decision, let it cross the synchroniser, check flag
	task toggle(input logic v, input logic f);
		@(posedge pclk);
		analog_compare <= v;
		repeat (6) @(posedge pclk);
		check({31'h0, irq}, {31'h0, f});
		apb(1'b0, `OFFSET_STATUS, 32'h0);
		check(rd & 32'h1, {31'h0, f});
		apb(1'b1, `OFFSET_STATUS, 32'h1);
	endtask : toggle

	// Hang guard, far beyond the expected run length
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, standby_sleep, analog_compare} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		repeat (4) @(posedge pclk);
		check({24'h0, div_code}, 32'hff);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, raddr[i], 32'h0);
			check(rd, rexp[i]);
		end
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			check(rd, rows[i].e);
		end
		check({28'h0, pos_sel, neg_sel}, 32'hf);
		check({26'h0, low_power_select, hys, comparator_on, pad_out_en,
			event_level}, 32'h3f);
		check({23'h0, pad_out, div_code}, 32'h15a);
		// Invert turned the idle output into a rising edge
		check({31'h0, irq}, 32'h1);
		apb(1'b0, `OFFSET_STATUS, 32'h0);
		check(rd, 32'h11);
		apb(1'b1, `OFFSET_STATUS, 32'h10);
		apb(1'b0, `OFFSET_STATUS, 32'h0);
		check(rd, 32'h11);
		apb(1'b1, `OFFSET_STATUS, 32'h1);
		apb(1'b0, `OFFSET_STATUS, 32'h0);
		check({rd[30:0], irq}, 32'h20);
		apb(1'b0, 12'h004, 32'h0);
		check({rd[30:0], err}, 32'h1);
		pstrb <= 4'h0;
		apb(1'b1, `OFFSET_REFERENCE, 32'h11);
		pstrb <= 4'hf;
		apb(1'b0, `OFFSET_REFERENCE, 32'h0);
		check(rd, 32'h5a);
		// Falling edge in rising-only mode must not flag
		apb(1'b1, `OFFSET_INPUT_SELECT, 32'h0);
		repeat (4) @(posedge pclk);
		apb(1'b0, `OFFSET_STATUS, 32'h0);
		check(rd, 32'h0);
		foreach (modes[i]) begin
			apb(1'b1, `OFFSET_CONTROL, {26'h0, modes[i], 4'h1});
			toggle(1'b1, modes[i] != `EDGE_FALLING);
			toggle(1'b0, modes[i] != `EDGE_RISING);
		end
		apb(1'b1, `OFFSET_CONTROL, 32'h0);
		toggle(1'b1, 1'b0);
		check({31'h0, comparator_on}, 32'h0);
		toggle(1'b0, 1'b0);
		apb(1'b1, `OFFSET_CONTROL, 32'h1);
		standby_sleep <= 1'b1;
		repeat (3) @(posedge pclk);
		check({31'h0, comparator_on}, 32'h0);
		apb(1'b1, `OFFSET_CONTROL, 32'h81);
		repeat (3) @(posedge pclk);
		check({31'h0, comparator_on}, 32'h1);
		toggle(1'b1, 1'b0);
		standby_sleep <= 1'b0;
		repeat (4) @(posedge pclk);
		finish_test();
	end
endmodule : comparator_control_regs_test
`default_nettype wire
